// ---- strs_cfg.svh ----
// constants for the suspend-to-ram sequencer
`ifndef STRS_CFG_SVH
`define STRS_CFG_SVH
`define STRS_REG_MODE_STATUS 8'h58
`define STRS_CTL_LSB 0
`define STRS_CTL_MSB 1
`define STRS_CTL_ENTER 2'h0
`define STRS_CTL_RESUME 2'h3
`define STRS_MODE_RESET 32'h0000_0000
`define STRS_CLK_TAIL_CYC 4'h6
`endif

// ---- strs_partner.sv ----
// southbridge and processor model facing the suspend sequencer
`timescale 1ns/100ps
module strs_partner (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic wake,
  input wire logic hold_bus_reset,
  input wire logic connect,
  input wire logic queue_flush_req,
  input wire logic sref_req,
  input wire logic pci_stop_grant_req,
  output strs_pkg::strs_evt_type evt,
  output logic clock_gate_request_n,
  output logic expansion_bus_reset_n
);
  // cpu 0 and memory answer in one cycle, cpu 1 one cycle after cpu 0; gate request always leads bus reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt <= '0;
      clock_gate_request_n <= 1'b1;
      expansion_bus_reset_n <= 1'b1;
    end else begin
      evt.stop_grant_p0 <= go;
      evt.stop_grant_p1 <= evt.stop_grant_p0;
      evt.queues_empty <= queue_flush_req;
      evt.processor_ready_ack <= connect;
      evt.sref_done <= sref_req;
      evt.pci_sg_done <= pci_stop_grant_req;
      if (wake) clock_gate_request_n <= 1'b1;
      else if (evt.pci_sg_done) clock_gate_request_n <= 1'b0;
      if (wake && clock_gate_request_n) expansion_bus_reset_n <= 1'b1;
      else if (!wake && !hold_bus_reset && !clock_gate_request_n) expansion_bus_reset_n <= 1'b0;
    end
  end
endmodule

// ---- strs_pkg.sv ----
// types for the suspend-to-ram sequencer
package strs_pkg;
  typedef enum logic [3:0] {
    STRS_RUN = 4'h0,
    STRS_FLUSH = 4'h1,
    STRS_DISC = 4'h3,
    STRS_SREF = 4'h2,
    STRS_PCI_SG = 4'h6,
    STRS_WAIT_GATE = 4'h7,
    STRS_GATED = 4'h5,
    STRS_SLEEP = 4'h4,
    STRS_RESUMED = 4'hC
  } strs_state_type;

  typedef struct packed {
    logic stop_grant_p0;
    logic stop_grant_p1;
    logic queues_empty;
    logic processor_ready_ack;
    logic sref_done;
    logic pci_sg_done;
  } strs_evt_type;

  typedef struct packed {
    strs_state_type st;
    logic sg0_seen;
    logic sg1_seen;
    logic str_sleep;
    logic [31:0] mode_status;
    logic [3:0] tail_cnt;
    logic connect;
    logic cke;
    logic flush_req;
    logic sref_req;
    logic pci_sg_req;
    logic clk_gate;
    logic pad_iso;
    logic dimm_clk_en;
    logic cmd_hold;
    logic [1:0] rst_sync;
    logic [1:0] gate_sync;
  } strs_state_all_type;
endpackage

// ---- strs_seq.sv ----
// suspend-to-ram entry and resume sequencer
// Contract
// - after stop-grant from both cpus, flush queues and probes, then drop connect
// - after disconnect, auto-refresh plus cke low enters self-refresh; wait done
// - pci stop-grant only after self-refresh is established
// - clock-gate request sampled active gates most internal clock trees
// - dimm clocks run six more periods after reset asserts
// - in suspend reset keep cke low and isolate io pads
// - in suspend reset gate cpu-bus, graphics and pci input clocks
// - all other memory configuration bits survive suspend reset
// - suspend control bits tell suspend resume from other reset exits; entry sets them to 2'h0, the same value cold reset leaves
// - firmware writes control bits; device then leaves self-refresh
// - on clock-gate request tri-state ddr address/command, keep cke low
`timescale 1ns/100ps
`include "strs_cfg.svh"
module strs_seq (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic expansion_bus_reset_n,
  input wire logic clock_gate_request_n,
  input wire strs_pkg::strs_evt_type evt,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic connect,
  output logic queue_flush_req,
  output logic sref_req,
  output logic pci_stop_grant_req,
  output logic dram_cke,
  output logic ddr_cmd_oe,
  output logic mem_cmd_hold,
  output logic clk_tree_gate,
  output logic pad_isolate,
  output logic input_clk_gate,
  output logic dimm_clock_outputs_en,
  output logic resume_from_str
);
  strs_pkg::strs_state_all_type s_r, s_nxt;
  logic rst_act, gate_act, mode_hit;

  // the register decode is used by reads and writes
  function automatic logic hit(input logic [7:0] a);
    hit = (a == `STRS_REG_MODE_STATUS);
  endfunction

  assign rst_act = ~s_r.rst_sync[1];
  assign gate_act = ~s_r.gate_sync[1];
  assign mode_hit = hit(cfg_addr);

  // next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.rst_sync = {s_r.rst_sync[0], expansion_bus_reset_n};
    s_nxt.gate_sync = {s_r.gate_sync[0], clock_gate_request_n};
    if (evt.stop_grant_p0) s_nxt.sg0_seen = 1'b1;
    if (evt.stop_grant_p1) s_nxt.sg1_seen = 1'b1;
    if (cfg_wr && mode_hit && !rst_act) begin
      s_nxt.mode_status = cfg_wdata;
    end
    case (s_r.st)
      strs_pkg::STRS_RUN: begin
        s_nxt.connect = 1'b1;
        s_nxt.cke = 1'b1;
        if (s_r.sg0_seen && s_r.sg1_seen) begin
          s_nxt.st = strs_pkg::STRS_FLUSH;
          s_nxt.flush_req = 1'b1;
        end
      end
      strs_pkg::STRS_FLUSH: begin
        if (evt.queues_empty) begin
          s_nxt.flush_req = 1'b0;
          s_nxt.connect = 1'b0;
          s_nxt.st = strs_pkg::STRS_DISC;
        end
      end
      strs_pkg::STRS_DISC: begin
        if (!evt.processor_ready_ack) begin
          s_nxt.sref_req = 1'b1;
          s_nxt.cke = 1'b0;
          s_nxt.cmd_hold = 1'b1;
          s_nxt.st = strs_pkg::STRS_SREF;
        end
      end
      strs_pkg::STRS_SREF: begin
        if (evt.sref_done) begin
          s_nxt.sref_req = 1'b0;
          s_nxt.pci_sg_req = 1'b1;
          s_nxt.st = strs_pkg::STRS_PCI_SG;
        end
      end
      strs_pkg::STRS_PCI_SG: begin
        if (evt.pci_sg_done) begin
          s_nxt.pci_sg_req = 1'b0;
          s_nxt.st = strs_pkg::STRS_WAIT_GATE;
        end
      end
      strs_pkg::STRS_WAIT_GATE: begin
        if (gate_act) begin
          s_nxt.clk_gate = 1'b1;
          s_nxt.st = strs_pkg::STRS_GATED;
        end
      end
      strs_pkg::STRS_GATED: begin
        if (rst_act) begin
          s_nxt.pad_iso = 1'b1;
          s_nxt.str_sleep = 1'b1;
          s_nxt.tail_cnt = `STRS_CLK_TAIL_CYC;
          s_nxt.mode_status[`STRS_CTL_MSB:`STRS_CTL_LSB] = `STRS_CTL_ENTER;
          s_nxt.st = strs_pkg::STRS_SLEEP;
        end else if (!gate_act) begin
          // plain power-on suspend exit: clocks back, reconnect; a stop grant arriving now still counts
          s_nxt.clk_gate = 1'b0;
          s_nxt.cke = 1'b1;
          s_nxt.cmd_hold = 1'b0;
          s_nxt.sg0_seen = evt.stop_grant_p0;
          s_nxt.sg1_seen = evt.stop_grant_p1;
          s_nxt.st = strs_pkg::STRS_RUN;
        end
      end
      strs_pkg::STRS_SLEEP: begin
        // clocks stop as the tail count leaves one, so exactly the full tail runs
        if (s_r.tail_cnt != 4'h0) s_nxt.tail_cnt = s_r.tail_cnt - 4'h1;
        if (s_r.tail_cnt <= 4'h1) s_nxt.dimm_clk_en = 1'b0;
        if (!gate_act) s_nxt.clk_gate = 1'b0;
        if (!rst_act) begin
          s_nxt.pad_iso = 1'b0;
          s_nxt.dimm_clk_en = 1'b1;
          s_nxt.st = strs_pkg::STRS_RESUMED;
        end
      end
      strs_pkg::STRS_RESUMED: begin
        // memory stays in self-refresh until firmware writes the control bits
        if (cfg_wr && mode_hit &&
            cfg_wdata[`STRS_CTL_MSB:`STRS_CTL_LSB] == `STRS_CTL_RESUME) begin
          s_nxt.cke = 1'b1;
          s_nxt.cmd_hold = 1'b0;
          s_nxt.str_sleep = 1'b0;
          s_nxt.clk_gate = 1'b0;
          s_nxt.connect = 1'b1;
          s_nxt.sg0_seen = evt.stop_grant_p0;
          s_nxt.sg1_seen = evt.stop_grant_p1;
          s_nxt.st = strs_pkg::STRS_RUN;
        end
      end
      default: s_nxt.st = strs_pkg::STRS_RUN;
    endcase
  end

  // state register; bus reset only acts through the sequence so config survives
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.st <= strs_pkg::STRS_RUN;
      s_r.mode_status <= `STRS_MODE_RESET;
      s_r.connect <= 1'b1;
      s_r.cke <= 1'b1;
      s_r.dimm_clk_en <= 1'b1;
      s_r.rst_sync <= 2'h3;
      s_r.gate_sync <= 2'h3;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // read data is registered
  logic [31:0] rdata_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) rdata_r <= 32'h0000_0000;
    else if (clk_en && cfg_rd) rdata_r <= mode_hit ? s_r.mode_status : 32'h0000_0000;
  end

  // outputs
  assign cfg_rdata = rdata_r;
  assign connect = s_r.connect;
  assign queue_flush_req = s_r.flush_req;
  assign sref_req = s_r.sref_req;
  assign pci_stop_grant_req = s_r.pci_sg_req;
  assign dram_cke = s_r.cke && !s_r.pad_iso;
  assign ddr_cmd_oe = !s_r.clk_gate && !s_r.pad_iso;
  assign mem_cmd_hold = s_r.cmd_hold;
  assign clk_tree_gate = s_r.clk_gate;
  assign pad_isolate = s_r.pad_iso;
  assign input_clk_gate = s_r.pad_iso;
  assign dimm_clock_outputs_en = s_r.dimm_clk_en;
  assign resume_from_str = (s_r.st == strs_pkg::STRS_RESUMED);

  // checks on the entry and resume sequence
  connect_flush_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_r.st == strs_pkg::STRS_FLUSH) |-> connect) else $error("connect lost before flush");
  sequence sref_up;
    (s_r.st == strs_pkg::STRS_SREF) && evt.sref_done && clk_en;
  endsequence
  pci_after_sref_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(pci_stop_grant_req) |-> $past(s_r.st) == strs_pkg::STRS_SREF) else $error("pci sg early");
  sref_seq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    sref_up |=> pci_stop_grant_req && !dram_cke) else $error("sref to pci step");
  cke_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    sref_req |-> !dram_cke) else $error("cke high in self-refresh");
  gate_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_tree_gate |-> !ddr_cmd_oe && !dram_cke) else $error("ddr bus driven while gated");
  gate_on_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_r.st == strs_pkg::STRS_WAIT_GATE) && gate_act && clk_en |=> clk_tree_gate && !ddr_cmd_oe)
    else $error("clock trees not gated");
  pad_iso_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_r.st == strs_pkg::STRS_SLEEP) |-> pad_isolate && input_clk_gate && !s_r.cke) else $error("pads not isolated");
  str_bits_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(pad_isolate) |-> s_r.mode_status[`STRS_CTL_MSB:`STRS_CTL_LSB] == `STRS_CTL_ENTER)
    else $error("control bits kept");
  cmd_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    resume_from_str |-> mem_cmd_hold && !dram_cke) else $error("memory left self-refresh");
  dimm_tail_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(pad_isolate) && clk_en |-> dimm_clock_outputs_en [*6]) else $error("dimm clock stopped early");
  wake_mem_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_r.st == strs_pkg::STRS_RESUMED) && cfg_wr && mode_hit && clk_en &&
    cfg_wdata[`STRS_CTL_MSB:`STRS_CTL_LSB] == `STRS_CTL_RESUME |=> dram_cke && !mem_cmd_hold && connect)
    else $error("memory kept in self-refresh after firmware write");
  freeze_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !clk_en |=> $stable(s_r)) else $error("state moved while clock enable low");
endmodule

// ---- test_suspend_to_ram_sequencer.sv ----
// self-checking bench for the suspend-to-ram sequencer
`timescale 1ns/100ps
`include "strs_cfg.svh"
module test_suspend_to_ram_sequencer;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic go = 1'b0;
  logic wake = 1'b0;
  logic hold_bus_reset = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic [31:0] cfg_rdata;
  logic connect, queue_flush_req, sref_req, pci_stop_grant_req, dram_cke, ddr_cmd_oe, mem_cmd_hold;
  logic clk_tree_gate, pad_isolate, input_clk_gate, dimm_clock_outputs_en, resume_from_str;
  logic clock_gate_request_n, expansion_bus_reset_n;
  strs_pkg::strs_evt_type evt;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  strs_seq i_strs_seq (.core_clk, .rst_n, .clk_en, .expansion_bus_reset_n, .clock_gate_request_n, .evt,
    .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata, .connect, .queue_flush_req, .sref_req,
    .pci_stop_grant_req, .dram_cke, .ddr_cmd_oe, .mem_cmd_hold, .clk_tree_gate, .pad_isolate,
    .input_clk_gate, .dimm_clock_outputs_en, .resume_from_str);
  strs_partner i_strs_partner (.core_clk, .rst_n, .go, .wake, .hold_bus_reset, .connect, .queue_flush_req, .sref_req,
    .pci_stop_grant_req, .evt, .clock_gate_request_n, .expansion_bus_reset_n);
  // clock source
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      finish_test();
    end
  end
  task finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // bounded wait for a level, then compare it
  task automatic wait_lvl(ref logic s, input logic v);
    int k;
    for (k = 0; k < 100 && s !== v; k++) @(posedge core_clk) #1;
    chk({31'h0, s}, {31'h0, v}, "wait level");
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge core_clk);
    cfg_rd <= 1'b0;
    #1;
    chk(cfg_rdata, exp, "read");
  endtask
  // reset, register, entry, resume, clock enable and power-on suspend tests
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk({31'h0, resume_from_str}, 32'h0, "cold exit flag");
    chk({31'h0, dram_cke}, 32'h1, "cke at reset");
    rd(`STRS_REG_MODE_STATUS, 32'h0000_0000);
    wr(`STRS_REG_MODE_STATUS, 32'h1234_5675);
    rd(8'h5C, 32'h0000_0000);
    $display("test reset and register done");
    @(posedge core_clk);
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    wait_lvl(queue_flush_req, 1'b1);
    chk({31'h0, connect}, 32'h1, "connect before flush");
    wait_lvl(connect, 1'b0);
    wait_lvl(dram_cke, 1'b0);
    chk({31'h0, sref_req}, 32'h1, "sref request");
    chk({31'h0, pci_stop_grant_req}, 32'h0, "early pci grant");
    wait_lvl(pci_stop_grant_req, 1'b1);
    wait_lvl(clk_tree_gate, 1'b1);
    chk({31'h0, ddr_cmd_oe}, 32'h0, "cmd drive");
    wait_lvl(pad_isolate, 1'b1);
    chk({31'h0, input_clk_gate}, 32'h1, "input clocks");
    chk({31'h0, dram_cke}, 32'h0, "cke in reset");
    n = 0;
    while (dimm_clock_outputs_en === 1'b1 && n < 20) begin
      @(posedge core_clk) #1;
      n++;
    end
    chk(n, {28'h0, `STRS_CLK_TAIL_CYC}, "dimm clock tail");
    wr(`STRS_REG_MODE_STATUS, 32'hFFFF_FFFF);
    rd(`STRS_REG_MODE_STATUS, 32'h1234_5674);
    $display("test suspend entry done");
    @(posedge core_clk);
    wake <= 1'b1;
    wait_lvl(resume_from_str, 1'b1);
    chk({31'h0, dimm_clock_outputs_en}, 32'h1, "dimm clocks back");
    chk({31'h0, mem_cmd_hold}, 32'h1, "command hold");
    chk({31'h0, dram_cke}, 32'h0, "cke before write");
    rd(`STRS_REG_MODE_STATUS, 32'h1234_5674);
    wr(`STRS_REG_MODE_STATUS, 32'h1234_5677);
    @(posedge core_clk) #1;
    chk({31'h0, dram_cke}, 32'h1, "cke after write");
    chk({31'h0, mem_cmd_hold}, 32'h0, "hold after write");
    chk({31'h0, connect}, 32'h1, "reconnect");
    $display("test resume done");
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(`STRS_REG_MODE_STATUS, 32'h0000_0000);
    @(posedge core_clk);
    clk_en <= 1'b1;
    rd(`STRS_REG_MODE_STATUS, 32'h1234_5677);
    $display("test clock enable done");
    @(posedge core_clk);
    wake <= 1'b0;
    hold_bus_reset <= 1'b1;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    wait_lvl(clk_tree_gate, 1'b1);
    repeat (6) @(posedge core_clk);
    #1;
    chk({31'h0, pad_isolate}, 32'h0, "isolate without bus reset");
    chk({31'h0, dimm_clock_outputs_en}, 32'h1, "dimm clocks in power-on suspend");
    @(posedge core_clk);
    wake <= 1'b1;
    wait_lvl(clk_tree_gate, 1'b0);
    wait_lvl(connect, 1'b1);
    chk({31'h0, dram_cke}, 32'h1, "cke after power-on suspend");
    chk({31'h0, mem_cmd_hold}, 32'h0, "hold after power-on suspend");
    chk({31'h0, resume_from_str}, 32'h0, "plain exit flag");
    rd(`STRS_REG_MODE_STATUS, 32'h1234_5677);
    $display("test power-on suspend done");
    finish_test();
  end
endmodule
